// ==== cdcr_defs.svh ====
`ifndef CDCR_DEFS_SVH
`define CDCR_DEFS_SVH

// Read frame layout
`define CDCR_FRAME_W 32
`define CDCR_OP_HI 31
`define CDCR_OP_LO 30
`define CDCR_ADDR_HI 29
`define CDCR_ADDR_LO 24
`define CDCR_DATA_W 24
`define CDCR_OP_READ 2'h1

// Word addresses
`define CDCR_ADDR_DTIME 6'h00
`define CDCR_ADDR_CRATIO 6'h01
`define CDCR_ADDR_STATUS 6'h08
`define CDCR_ADDR_RRATIO 6'h0e

// Status word values
`define CDCR_STAT_NONE 24'h000000
`define CDCR_STAT_CAP_OK 24'h100000
`define CDCR_STAT_ALL_OK 24'h900000

// Fixed-point format of the ratio words: 3.21 unsigned
`define CDCR_RATIO_INT_BITS 3
`define CDCR_RATIO_FRAC_BITS 21

// Typical time bin of the discharge count, in ps
`define CDCR_BIN_PS 21

// Host wait after start before reading, in ms, and in cycles at 250 MHz
`define CDCR_CLK_MHZ 250
`define CDCR_HOST_WAIT_MS 100
`define CDCR_HOST_WAIT_CYC (`CDCR_HOST_WAIT_MS * 1000 * `CDCR_CLK_MHZ)

// Default sequence timer period in cycles and rate counter width
`define CDCR_SEQ_PERIOD 32'h000003e8
`define CDCR_DIV_W 16

`endif

// ==== cdcr_pkg.sv ====
package cdcr_pkg;
  // Measurement run state
  typedef enum logic [0:0] {
    CDCR_IDLE = 1'b0,
    CDCR_RUN  = 1'b1
  } cdcr_state_e;

  // Word address of a read frame
  typedef logic [5:0] cdcr_addr_t;
  // Contents of one 24-bit word
  typedef logic [23:0] cdcr_word_t;
endpackage : cdcr_pkg

// ==== cdcr_tick_div.sv ====
// Counts step pulses and emits one tick every period steps
module cdcr_tick_div #(
  parameter int W = 16
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic step_i,
  input wire logic [W-1:0] period_i,
  output logic tick_o
);
  logic [W-1:0] cnt_q; // Steps seen since last tick
  logic [W-1:0] cnt_d;
  logic last; // Current step closes the period

  // Period 0 behaves as 1 so the divider never stalls
  always_comb begin
    last = (period_i == '0) || (cnt_q >= period_i - W'(1));
    cnt_d = cnt_q;
    if (!en_i) begin
      cnt_d = '0;
    end else if (step_i) begin
      cnt_d = last ? '0 : cnt_q + W'(1);
    end
  end

  assign tick_o = en_i && step_i && last;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : cdcr_tick_div

// ==== cdcr_result_readout.sv ====
// Function
// - Read frame 01, 6-bit address, 24-bit data
// - Status at 8, results at 0, 1, 14
// - Completed measurement reports status 100000 or 900000
// - Word 0 is unsigned discharge bin count
// - Capacitance ratio is unsigned 3.21 fixed point
// - Resistance ratio uses same 2^21 scaling
// - Sequence timer starts each capacitance run
// - Capacitance end triggers temperature, optional divider
`include "cdcr_defs.svh"

module cdcr_result_readout #(
  parameter int DIV_W = `CDCR_DIV_W,
  parameter logic [31:0] SEQ_PERIOD = `CDCR_SEQ_PERIOD
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Command side, from the serial interface logic
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic frame_valid_i,
  input wire logic [31:0] frame_i,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  // Mode controls
  input wire logic seq_timer_mode_i,
  input wire logic rdc_after_cdc_i,
  input wire logic [DIV_W-1:0] rdc_div_i,
  // Front end
  output logic cdc_start_o,
  input wire logic cdc_done_i,
  input wire logic [23:0] discharge_time_i,
  input wire logic [23:0] capacitance_ratio_i,
  output logic rdc_start_o,
  input wire logic rdc_done_i,
  input wire logic [23:0] resistance_ratio_i,
  output logic running_o
);
  cdcr_pkg::cdcr_state_e state_q; // Run state
  cdcr_pkg::cdcr_state_e state_d;
  logic enter_q; // First cycle of a run
  logic enter_d;
  cdcr_pkg::cdcr_word_t discharge_time_result_q; // Bin count
  cdcr_pkg::cdcr_word_t discharge_time_result_d;
  cdcr_pkg::cdcr_word_t capacitance_ratio_result_q; // 3.21 ratio
  cdcr_pkg::cdcr_word_t capacitance_ratio_result_d;
  cdcr_pkg::cdcr_word_t resistance_ratio_result_q; // 3.21 ratio
  cdcr_pkg::cdcr_word_t resistance_ratio_result_d;
  logic cap_ok_q; // A capacitance run has finished
  logic cap_ok_d;
  logic res_ok_q; // A temperature run has finished
  logic res_ok_d;
  cdcr_pkg::cdcr_word_t status_word; // Live status
  logic rd_valid_q;
  logic rd_valid_d;
  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;
  logic seq_tick; // Sequence timer period elapsed
  logic rdc_tick; // Rate counter let a temperature run through
  logic run;
  cdcr_pkg::cdcr_addr_t rd_addr;
  cdcr_pkg::cdcr_word_t rd_word;

  assign run = (state_q == cdcr_pkg::CDCR_RUN);

  // Internal timer, stepping every clock while in sequence mode
  cdcr_tick_div #(.W(32)) u_seq_timer (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .en_i(run && seq_timer_mode_i),
    .step_i(1'b1),
    .period_i(SEQ_PERIOD),
    .tick_o(seq_tick)
  );

  // Rate counter between capacitance ends and temperature starts
  cdcr_tick_div #(.W(DIV_W)) u_rdc_div (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .en_i(run && rdc_after_cdc_i),
    .step_i(cdc_done_i),
    .period_i(rdc_div_i),
    .tick_o(rdc_tick)
  );

  // Run control; stop wins over start
  always_comb begin
    state_d = state_q;
    enter_d = 1'b0;
    case (state_q)
      cdcr_pkg::CDCR_IDLE: begin
        if (start_i && !stop_i) begin
          state_d = cdcr_pkg::CDCR_RUN;
          enter_d = 1'b1;
        end
      end
      cdcr_pkg::CDCR_RUN: begin
        if (stop_i) begin
          state_d = cdcr_pkg::CDCR_IDLE;
        end
      end
      default: begin
        state_d = cdcr_pkg::CDCR_IDLE;
      end
    endcase
  end

  // Timer mode needs no outside trigger; continuous mode chains runs
  assign cdc_start_o = run && (seq_timer_mode_i ? seq_tick : (enter_q || cdc_done_i));
  // Temperature follows capacitance end through the rate counter
  assign rdc_start_o = rdc_tick;
  assign running_o = run;

  // Result capture; a start clears the status so stale words are not taken as new
  always_comb begin
    discharge_time_result_d = discharge_time_result_q;
    capacitance_ratio_result_d = capacitance_ratio_result_q;
    resistance_ratio_result_d = resistance_ratio_result_q;
    cap_ok_d = cap_ok_q;
    res_ok_d = res_ok_q;
    if (enter_d) begin
      cap_ok_d = 1'b0;
      res_ok_d = 1'b0;
    end
    if (cdc_done_i && run) begin
      discharge_time_result_d = discharge_time_i;
      capacitance_ratio_result_d = capacitance_ratio_i;
      cap_ok_d = 1'b1;
    end
    if (rdc_done_i && run) begin
      resistance_ratio_result_d = resistance_ratio_i;
      res_ok_d = 1'b1;
    end
  end

  // Status shows the extra flag once a temperature run has also ended
  always_comb begin
    status_word = `CDCR_STAT_NONE;
    if (cap_ok_q) begin
      status_word = res_ok_q ? `CDCR_STAT_ALL_OK : `CDCR_STAT_CAP_OK;
    end
  end

  // Read frame decode; other opcodes are not answered
  assign rd_addr = frame_i[`CDCR_ADDR_HI:`CDCR_ADDR_LO];
  always_comb begin
    case (rd_addr)
      `CDCR_ADDR_DTIME: rd_word = discharge_time_result_q;
      `CDCR_ADDR_CRATIO: rd_word = capacitance_ratio_result_q;
      `CDCR_ADDR_STATUS: rd_word = status_word;
      `CDCR_ADDR_RRATIO: rd_word = resistance_ratio_result_q;
      default: rd_word = '0;
    endcase
    rd_valid_d = frame_valid_i && (frame_i[`CDCR_OP_HI:`CDCR_OP_LO] == `CDCR_OP_READ);
    rd_data_d = rd_data_q;
    if (rd_valid_d) begin
      rd_data_d = {`CDCR_OP_READ, rd_addr, rd_word};
    end
  end

  assign rd_valid_o = rd_valid_q;
  assign rd_data_o = rd_data_q;

  // Registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= cdcr_pkg::CDCR_IDLE;
      enter_q <= 1'b0;
      discharge_time_result_q <= '0;
      capacitance_ratio_result_q <= '0;
      resistance_ratio_result_q <= '0;
      cap_ok_q <= 1'b0;
      res_ok_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      state_q <= state_d;
      enter_q <= enter_d;
      discharge_time_result_q <= discharge_time_result_d;
      capacitance_ratio_result_q <= capacitance_ratio_result_d;
      resistance_ratio_result_q <= resistance_ratio_result_d;
      cap_ok_q <= cap_ok_d;
      res_ok_q <= res_ok_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
    end
  end

  // Checks
  a_frame_format: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    frame_valid_i && frame_i[31:30] == 2'b01 |=> rd_valid_o && rd_data_o[31:30] == 2'b01
    && rd_data_o[29:24] == $past(frame_i[29:24]))
    else $error("read answer malformed");
  a_status_addr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    frame_valid_i && frame_i[31:24] == 8'h48 |=> rd_data_o[23:0] == $past(status_word))
    else $error("status not at address 8");
  a_rratio_addr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    frame_valid_i && frame_i[31:24] == 8'h4e |=> rd_data_o[23:0] == $past(resistance_ratio_result_q))
    else $error("resistance ratio not at address 14");
  a_status_value: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    run && cdc_done_i && !start_i |=> status_word == 24'h100000 || status_word == 24'h900000)
    else $error("status after run wrong");
  a_dtime_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    run && cdc_done_i ##1 frame_valid_i && frame_i[31:24] == 8'h40 && !cdc_done_i
    |=> rd_data_o[23:0] == $past(discharge_time_i, 2))
    else $error("discharge count not returned");
  a_cratio_read: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    run && cdc_done_i ##1 frame_valid_i && frame_i[31:24] == 8'h41 && !cdc_done_i
    |=> rd_data_o[23:0] == $past(capacitance_ratio_i, 2))
    else $error("capacitance ratio not returned");
  a_rratio_keep: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    run && rdc_done_i |=> resistance_ratio_result_q == $past(resistance_ratio_i))
    else $error("resistance ratio not captured");
  a_timer_start: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    run && seq_timer_mode_i |-> cdc_start_o == seq_tick)
    else $error("timer mode start not on timer tick");
  a_temp_follow: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    rdc_start_o |-> cdc_done_i && rdc_after_cdc_i && run)
    else $error("temperature start without capacitance end");
endmodule : cdcr_result_readout

// ==== cdcr_front_model.sv ====
// Front-end model: answers each start with a done pulse lat_i + 1 cycles later
module cdcr_front_model #(
  parameter logic [23:0] DT_VAL = 24'h011170,
  parameter logic [23:0] CR_VAL = 24'h1ff2a0,
  parameter logic [23:0] RR_VAL = 24'h1ab3f0
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic cdc_start_i,
  input wire logic rdc_start_i,
  input wire logic [7:0] lat_i,
  output logic cdc_done_o,
  output logic rdc_done_o,
  output logic [23:0] discharge_time_o,
  output logic [23:0] capacitance_ratio_o,
  output logic [23:0] resistance_ratio_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_c; // Cycles left in the capacitance run
  logic [7:0] cnt_r; // Cycles left in the temperature run
  // Every start reloads its counter; done pulses as the count runs out
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_c <= 8'h00;
      cnt_r <= 8'h00;
      cdc_done_o <= 1'b0;
      rdc_done_o <= 1'b0;
    end else begin
      cdc_done_o <= (cnt_c == 8'h01);
      rdc_done_o <= (cnt_r == 8'h01);
      cnt_c <= cdc_start_i ? lat_i : (cnt_c != 8'h00 ? cnt_c - 8'h01 : 8'h00);
      cnt_r <= rdc_start_i ? lat_i : (cnt_r != 8'h00 ? cnt_r - 8'h01 : 8'h00);
    end
  end
  // Results valid in the done cycle only; inverted otherwise so late capture shows
  assign discharge_time_o = cdc_done_o ? DT_VAL : ~DT_VAL;
  assign capacitance_ratio_o = cdc_done_o ? CR_VAL : ~CR_VAL;
  assign resistance_ratio_o = rdc_done_o ? RR_VAL : ~RR_VAL;
endmodule : cdcr_front_model

// ==== test_cdc_result_readout.sv ====
module test_cdc_result_readout;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, start, stop, fv, tm, rac, rv, cs, cd, rs, rd, run;
  logic [31:0] frame, rdat;
  logic [15:0] div;
  logic [23:0] dt, cr, rr;
  logic [7:0] lat;
  int fails, checks_done;
  // Front-end results: 70000 bins, ratio near one, ratio near 0.83
  localparam logic [23:0] DT = 24'h011170, CR = 24'h1ff2a0, RR = 24'h1ab3f0;
  // Short timer period keeps the run brief
  cdcr_result_readout #(.SEQ_PERIOD(32'h00000014)) dut_u (.ref_clk_i(clk), .nrst_i(nrst),
    .start_i(start), .stop_i(stop), .frame_valid_i(fv), .frame_i(frame), .rd_valid_o(rv),
    .rd_data_o(rdat), .seq_timer_mode_i(tm), .rdc_after_cdc_i(rac), .rdc_div_i(div),
    .cdc_start_o(cs), .cdc_done_i(cd), .discharge_time_i(dt), .capacitance_ratio_i(cr),
    .rdc_start_o(rs), .rdc_done_i(rd), .resistance_ratio_i(rr), .running_o(run));
  cdcr_front_model #(.DT_VAL(DT), .CR_VAL(CR), .RR_VAL(RR)) fe_u (.ref_clk_i(clk), .nrst_i(nrst),
    .cdc_start_i(cs), .rdc_start_i(rs), .lat_i(lat), .cdc_done_o(cd), .rdc_done_o(rd),
    .discharge_time_o(dt), .capacitance_ratio_o(cr), .resistance_ratio_o(rr));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task stop_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // One read frame; the answer is looked at in its single valid cycle
  task rd_word(input logic [1:0] op, input logic [5:0] a, output logic [31:0] v, output logic ok);
    @(negedge clk);
    fv = 1'b1;
    frame = {op, a, 24'h000000};
    @(negedge clk);
    fv = 1'b0;
    ok = rv;
    v = rdat;
  endtask : rd_word
  task exp_word(input logic [5:0] a, input logic [23:0] w);
    logic [31:0] v;
    logic ok;
    rd_word(2'h1, a, v, ok);
    chk({31'h0, ok}, 32'h1);
    chk(v, {2'h1, a, w});
  endtask : exp_word
  task pulse(input bit halt);
    @(negedge clk);
    if (halt) stop = 1'b1;
    else start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    stop = 1'b0;
  endtask : pulse
  // Host waits for a done pulse before reading; returns while the pulse stands
  // so that a read can follow in the very next cycle
  task wait_done(input bit temp);
    int n;
    n = 0;
    while ((temp ? rd : cd) !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, n < 200}, 32'h1);
  endtask : wait_done
  task t_idle;
    logic [31:0] v;
    logic ok;
    exp_word(6'h08, 24'h000000);
    exp_word(6'h3f, 24'h000000);
    rd_word(2'h3, 6'h08, v, ok);
    chk({31'h0, ok}, 32'h0);
    $display("test idle done");
  endtask : t_idle
  task t_cont;
    tm = 1'b0;
    rac = 1'b0;
    pulse(1'b0);
    chk({30'h0, cs, run}, 32'h3);
    wait_done(1'b0);
    exp_word(6'h00, DT);
    wait_done(1'b0);
    exp_word(6'h01, CR);
    exp_word(6'h08, 24'h100000);
    pulse(1'b1);
    chk({31'h0, run}, 32'h0);
    $display("test continuous done");
  endtask : t_cont
  task t_temp;
    int nc, nr;
    nc = 0;
    nr = 0;
    tm = 1'b0;
    rac = 1'b1;
    div = 16'h0002;
    pulse(1'b0);
    repeat (60) begin
      @(negedge clk);
      nc += int'(cd === 1'b1);
      nr += int'(rs === 1'b1 && cd === 1'b1);
    end
    chk({31'h0, nc > 8}, 32'h1);
    chk(nr, nc / 2);
    wait_done(1'b1);
    exp_word(6'h08, 24'h900000);
    exp_word(6'h0e, RR);
    pulse(1'b1);
    $display("test temperature done");
  endtask : t_temp
  task t_timer;
    int n;
    n = 0;
    tm = 1'b1;
    rac = 1'b0;
    pulse(1'b0);
    while (cs !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cs !== 1'b1 && n < 100);
    chk(n, 20);
    pulse(1'b1);
    $display("test timer done");
  endtask : t_timer
  // Stop wins over a start in the same cycle; rate setting 0 acts as 1; reset in mid-run
  task t_edge;
    int nc, nr;
    nc = 0;
    nr = 0;
    @(negedge clk);
    start = 1'b1;
    stop = 1'b1;
    @(negedge clk);
    start = 1'b0;
    stop = 1'b0;
    chk({31'h0, run}, 32'h0);
    tm = 1'b0;
    rac = 1'b1;
    div = 16'h0000;
    pulse(1'b0);
    repeat (30) begin
      @(negedge clk);
      nc += int'(cd === 1'b1);
      nr += int'(rs === 1'b1 && cd === 1'b1);
    end
    chk({31'h0, nc > 3}, 32'h1);
    chk(nr, nc);
    // Reset while running clears the run and every word
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    chk({31'h0, run}, 32'h0);
    exp_word(6'h08, 24'h000000);
    exp_word(6'h0e, 24'h000000);
    $display("test edge cases done");
  endtask : t_edge
  // Main sequence
  initial begin
    {nrst, start, stop, fv, tm, rac} = 6'h00;
    frame = 32'h00000000;
    div = 16'h0001;
    lat = 8'h04;
    fails = 0;
    checks_done = 0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_idle();
    t_cont();
    t_temp();
    t_timer();
    t_edge();
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule : test_cdc_result_readout
